// ==== core/hsp_buf.sv ====
`timescale 1ns/10ps
// Small valid/ready buffer; a stalled drain side fills it and drops in_ready
module hsp_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage needs no reset; cnt_q guards every read
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers wrap at DEPTH
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== core/hsp_if.sv ====
`timescale 1ns/10ps
// Open-drain two-wire bus; each line is high unless someone pulls low
interface hsp_if;
  logic scl_m_o;
  logic scl_m_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_t_o;
  logic sda_t_oe_n;
  logic scl;
  logic sda;

  // Wired-AND resolution with pull-ups
  assign scl = scl_m_oe_n | scl_m_o;
  assign sda = (sda_m_oe_n | sda_m_o) & (sda_t_oe_n | sda_t_o);

  modport master (output scl_m_o, output scl_m_oe_n, output sda_m_o, output sda_m_oe_n,
                  input scl, input sda);
  modport target (output sda_t_o, output sda_t_oe_n, input scl, input sda);
endinterface

// ==== core/hsp_master.sv ====
`timescale 1ns/10ps
// Host bus controller: software issues start, byte write, byte read and stop
module hsp_master
  import hsp_pkg::*;
#(
  parameter int QTR_CYC = SCL_QTR_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  hsp_if.master           bus,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata_q
);
  typedef enum logic [4:0] {
    HSP_H_IDLE  = 5'b00001,
    HSP_H_START = 5'b00010,
    HSP_H_WAIT  = 5'b00100,
    HSP_H_BIT   = 5'b01000,
    HSP_H_STOP  = 5'b10000
  } hsp_hstate_t;

  // ----------------------------------------------------------------
  // Input synchroniser and transmit buffer
  // ----------------------------------------------------------------
  logic sda_s1_q;
  logic sda_s2_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      sda_s1_q <= bus.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  hsp_hstate_t st_q;
  logic        tx_ready;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_pop;
  logic        cmd_go;

  // Engine drains the buffer; it stalls in WAIT when software is slow
  hsp_buf #(.WIDTH(8), .DEPTH(2)) u_txbuf (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .in_valid (reg_wr && reg_addr == HREG_TXDATA),
    .in_ready (tx_ready),
    .in_data  (reg_wdata),
    .out_valid(tx_valid),
    .out_ready(tx_pop),
    .out_data (tx_data)
  );

  assign cmd_go = reg_wr & (reg_addr == HREG_CMD) & (st_q == HSP_H_IDLE);
  assign tx_pop = tx_valid & ((st_q == HSP_H_WAIT) |
                  (cmd_go & (reg_wdata[1:0] == OP_WRITE)));

  // ----------------------------------------------------------------
  // Bit engine; four quarter periods per SCL bit
  // ----------------------------------------------------------------
  logic [15:0] qcnt_q;
  logic [1:0]  ph_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q;
  logic        rd_q;
  logic        ack_val_q;
  logic        nack_q;
  logic [7:0]  rx_q;
  logic        rx_valid_q;
  logic        scl_oe_n_q;
  logic        sda_oe_n_q;
  logic        pin_lo_q;
  logic        tick;

  assign tick = (qcnt_q == 16'h0000);

  // Commands arriving while busy are dropped; STATUS shows busy
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= HSP_H_IDLE;
      qcnt_q     <= 16'h0000;
      ph_q       <= 2'h0;
      bit_q      <= 4'h0;
      sh_q       <= 8'h00;
      rd_q       <= 1'b0;
      ack_val_q  <= 1'b0;
      nack_q     <= 1'b0;
      rx_q       <= 8'h00;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else if (cmd_go) begin
      qcnt_q    <= 16'(QTR_CYC - 1);
      ph_q      <= 2'h0;
      bit_q     <= 4'h0;
      rd_q      <= (reg_wdata[1:0] == OP_READ);
      ack_val_q <= reg_wdata[CMD_NACK_BIT];
      sh_q      <= (reg_wdata[1:0] == OP_READ) ? 8'hFF : tx_data;
      case (reg_wdata[1:0])
        OP_START: st_q <= HSP_H_START;
        OP_WRITE: st_q <= tx_valid ? HSP_H_BIT : HSP_H_WAIT;
        OP_READ:  st_q <= HSP_H_BIT;
        default:  st_q <= HSP_H_STOP;
      endcase
    end else if (st_q == HSP_H_WAIT) begin
      if (tx_valid) begin
        sh_q <= tx_data;
        st_q <= HSP_H_BIT;
      end
    end else if (st_q != HSP_H_IDLE) begin
      qcnt_q <= tick ? 16'(QTR_CYC - 1) : qcnt_q - 16'h0001;
      if (tick) begin
        ph_q <= ph_q + 2'h1;
        case (st_q)
          HSP_H_START: begin
            // Release SDA first so a repeated start sees it high under SCL high
            case (ph_q)
              2'h0:    sda_oe_n_q <= 1'b1;
              2'h1:    scl_oe_n_q <= 1'b1;
              2'h2:    sda_oe_n_q <= 1'b0;
              default: begin
                scl_oe_n_q <= 1'b0;
                st_q       <= HSP_H_IDLE;
              end
            endcase
          end
          HSP_H_BIT: begin
            case (ph_q)
              2'h0: begin
                // Data moves only with SCL low
                if (bit_q < 4'(BYTE_BITS)) begin
                  sda_oe_n_q <= rd_q | sh_q[7];
                end else begin
                  sda_oe_n_q <= ~rd_q | ack_val_q;
                end
              end
              2'h1: scl_oe_n_q <= 1'b1;
              2'h2: begin
                if (bit_q < 4'(BYTE_BITS)) begin
                  sh_q <= {sh_q[6:0], sda_s2_q};
                end else if (!rd_q) begin
                  nack_q <= sda_s2_q;
                end
              end
              default: begin
                scl_oe_n_q <= 1'b0;
                bit_q      <= bit_q + 4'h1;
                if (bit_q == 4'(BYTE_BITS)) begin
                  if (rd_q) begin
                    rx_q <= sh_q;
                  end
                  st_q <= HSP_H_IDLE;
                end
              end
            endcase
          end
          default: begin
            case (ph_q)
              2'h0:    sda_oe_n_q <= 1'b0;
              2'h1:    scl_oe_n_q <= 1'b1;
              2'h2:    sda_oe_n_q <= 1'b1;
              default: st_q <= HSP_H_IDLE;
            endcase
          end
        endcase
      end
    end
  end

  // Received-byte flag; a new byte in the read cycle keeps it set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid_q <= 1'b0;
    end else if (st_q == HSP_H_BIT && tick && ph_q == 2'h3 && bit_q == 4'(BYTE_BITS) && rd_q) begin
      rx_valid_q <= 1'b1;
    end else if (reg_rd && reg_addr == HREG_RXDATA) begin
      rx_valid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register read port and pins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
      pin_lo_q    <= 1'b0;
    end else begin
      pin_lo_q    <= 1'b0;
      reg_rdata_q <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          HREG_STATUS: begin
            reg_rdata_q[ST_BUSY]     <= (st_q != HSP_H_IDLE);
            reg_rdata_q[ST_NACK]     <= nack_q;
            reg_rdata_q[ST_TX_FULL]  <= ~tx_ready;
            reg_rdata_q[ST_TX_EMPTY] <= ~tx_valid;
            reg_rdata_q[ST_RX_VALID] <= rx_valid_q;
          end
          HREG_RXDATA: reg_rdata_q <= rx_q;
          default:     reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign bus.scl_m_o    = pin_lo_q;
  assign bus.sda_m_o    = pin_lo_q;
  assign bus.scl_m_oe_n = scl_oe_n_q;
  assign bus.sda_m_oe_n = sda_oe_n_q;
endmodule

// ==== core/hsp_pkg.sv ====
package hsp_pkg;
  // ----------------------------------------------------------------
  // Bus addressing and target register map
  // ----------------------------------------------------------------
  localparam logic [6:0] TGT_ADDR       = 7'h59;
  localparam logic [7:0] REG_LAUNCH     = 8'h02;
  localparam logic [7:0] REG_SLOT_FIRST = 8'h03;
  localparam logic [7:0] REG_SLOT_SECOND = 8'h04;
  localparam int         SLOT_COUNT     = 8;
  localparam int         LAUNCH_BIT     = 0;
  localparam logic [7:0] SLOT_RESET     = 8'h00;
  localparam logic [7:0] WAVE_END_ID    = 8'h00;

  // ----------------------------------------------------------------
  // Host controller register map
  // ----------------------------------------------------------------
  localparam logic [3:0] HREG_CMD    = 4'h0;
  localparam logic [3:0] HREG_STATUS = 4'h1;
  localparam logic [3:0] HREG_TXDATA = 4'h2;
  localparam logic [3:0] HREG_RXDATA = 4'h3;
  localparam logic [1:0] OP_START    = 2'h0;
  localparam logic [1:0] OP_WRITE    = 2'h1;
  localparam logic [1:0] OP_READ     = 2'h2;
  localparam logic [1:0] OP_STOP     = 2'h3;
  localparam int         CMD_NACK_BIT = 2;
  localparam int         ST_BUSY     = 0;
  localparam int         ST_NACK     = 1;
  localparam int         ST_TX_FULL  = 2;
  localparam int         ST_TX_EMPTY = 3;
  localparam int         ST_RX_VALID = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int BYTE_BITS     = 8;
endpackage

// ==== core/hsp_target.sv ====
// Overview of operation
// - Eight waveform slots loaded by the host
// - Slot value is a waveform index
// - Launch bit starts playback at slot 0x03
// - Advance to next slot only if non-zero
// - Stop at zero identifier or eight slots
// - Bytes are eight bits, MSB first
// - Receiver acknowledges every byte but the last read byte
// - SDA fall/rise with SCL high: start/stop
// - SDA changes only while SCL low
// - Master frames transfers with start and stop
// - Master sends address, direction, awaits acknowledge
// - Acknowledge holds SDA low whole clock
// - No limit on bytes per transfer
// - Target answers address 0x59 only
// - Lines are open-drain, wired-AND
// - Register pointer increments per data byte
// - Writes: direction 0, pointer byte first
// - Reads: repeated start, NACK last byte
`timescale 1ns/10ps
module hsp_target
  import hsp_pkg::*;
#(
  parameter int SLOTS = SLOT_COUNT
) (
  input  wire logic  sys_clk,
  input  wire logic  rst_n,
  hsp_if.target      bus,
  output logic [7:0] wave_id_q,
  output logic       wave_start_q,
  input  wire logic  wave_done,
  output logic       seq_busy_q
);
  localparam int SW = $clog2(SLOTS);

  typedef enum logic [4:0] {
    HSP_T_IDLE = 5'b00001,
    HSP_T_RX   = 5'b00010,
    HSP_T_ACK  = 5'b00100,
    HSP_T_TX   = 5'b01000,
    HSP_T_RACK = 5'b10000
  } hsp_tstate_t;

  typedef enum logic [2:0] {
    HSP_PH_ADDR = 3'b001,
    HSP_PH_PTR  = 3'b010,
    HSP_PH_DATA = 3'b100
  } hsp_phase_t;

  typedef enum logic [1:0] {
    HSP_SQ_IDLE = 2'b01,
    HSP_SQ_PLAY = 2'b10
  } hsp_sstate_t;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic scl_s1_q;
  logic scl_s2_q;
  logic scl_p_q;
  logic sda_s1_q;
  logic sda_s2_q;
  logic sda_p_q;

  // Two flops per pin, then a third stage for edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_p_q  <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_p_q  <= 1'b1;
    end else begin
      scl_s1_q <= bus.scl;
      scl_s2_q <= scl_s1_q;
      scl_p_q  <= scl_s2_q;
      sda_s1_q <= bus.sda;
      sda_s2_q <= sda_s1_q;
      sda_p_q  <= sda_s2_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_s2_q & ~scl_p_q;
  assign scl_fall  = ~scl_s2_q & scl_p_q;
  assign start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign stop_det  = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  slot_q [SLOTS];
  logic [7:0]  ptr_q;
  logic [7:0]  shift_q;
  logic [3:0]  bcnt_q;
  logic        rw_q;
  logic        nack_q;
  logic        sda_oe_n_q;
  logic        pin_lo_q;
  hsp_tstate_t st_q;
  hsp_phase_t  ph_q;
  logic        byte_done;
  logic        wr_stb;
  logic [7:0]  rd_byte;

  // Read value of one register address
  function automatic logic [7:0] reg_val(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == REG_LAUNCH) begin
      v[LAUNCH_BIT] = seq_busy_q;
    end else if (a >= REG_SLOT_FIRST && a < REG_SLOT_FIRST + 8'(SLOTS)) begin
      v = slot_q[SW'(a - REG_SLOT_FIRST)];
    end
    return v;
  endfunction

  assign byte_done = (st_q == HSP_T_RX) & scl_fall & (bcnt_q == 4'(BYTE_BITS));
  assign wr_stb    = byte_done & (ph_q == HSP_PH_DATA);
  // Byte to be shifted out for the current pointer
  assign rd_byte   = reg_val(ptr_q);

  // ----------------------------------------------------------------
  // Bus protocol engine
  // ----------------------------------------------------------------
  // Start and stop are checked first: they abort any byte in flight
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= HSP_T_IDLE;
      ph_q       <= HSP_PH_ADDR;
      ptr_q      <= 8'h00;
      shift_q    <= 8'h00;
      bcnt_q     <= 4'h0;
      rw_q       <= 1'b0;
      nack_q     <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (start_det) begin
      st_q       <= HSP_T_RX;
      ph_q       <= HSP_PH_ADDR;
      bcnt_q     <= 4'h0;
      sda_oe_n_q <= 1'b1;
    end else if (stop_det) begin
      st_q       <= HSP_T_IDLE;
      sda_oe_n_q <= 1'b1;
    end else begin
      case (st_q)
        HSP_T_RX: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s2_q};
            bcnt_q  <= bcnt_q + 4'h1;
          end else if (byte_done) begin
            sda_oe_n_q <= 1'b0;
            st_q       <= HSP_T_ACK;
            case (ph_q)
              HSP_PH_ADDR: begin
                if (shift_q[7:1] == TGT_ADDR) begin
                  rw_q <= shift_q[0];
                  ph_q <= HSP_PH_PTR;
                end else begin
                  sda_oe_n_q <= 1'b1;
                  st_q       <= HSP_T_IDLE;
                end
              end
              HSP_PH_PTR: begin
                ptr_q <= shift_q;
                ph_q  <= HSP_PH_DATA;
              end
              default: begin
                ptr_q <= ptr_q + 8'h01;
              end
            endcase
          end
        end
        HSP_T_ACK: begin
          // Release only after SCL falls, so the low spans the whole pulse
          if (scl_fall) begin
            bcnt_q <= 4'h0;
            if (rw_q && ph_q == HSP_PH_PTR) begin
              shift_q    <= reg_val(ptr_q);
              sda_oe_n_q <= rd_byte[7];
              ptr_q      <= ptr_q + 8'h01;
              st_q       <= HSP_T_TX;
            end else begin
              sda_oe_n_q <= 1'b1;
              st_q       <= HSP_T_RX;
            end
          end
        end
        HSP_T_TX: begin
          if (scl_fall) begin
            if (bcnt_q == 4'(BYTE_BITS - 1)) begin
              sda_oe_n_q <= 1'b1;
              st_q       <= HSP_T_RACK;
            end else begin
              shift_q    <= {shift_q[6:0], 1'b0};
              sda_oe_n_q <= shift_q[6];
              bcnt_q     <= bcnt_q + 4'h1;
            end
          end
        end
        HSP_T_RACK: begin
          if (scl_rise) begin
            nack_q <= sda_s2_q;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_q <= HSP_T_IDLE;
            end else begin
              shift_q    <= reg_val(ptr_q);
              sda_oe_n_q <= rd_byte[7];
              ptr_q      <= ptr_q + 8'h01;
              bcnt_q     <= 4'h0;
              st_q       <= HSP_T_TX;
            end
          end
        end
        default: begin
          sda_oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // Pad output level is always low; only the enable moves
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_lo_q <= 1'b0;
    end else begin
      pin_lo_q <= 1'b0;
    end
  end

  assign bus.sda_t_o    = pin_lo_q;
  assign bus.sda_t_oe_n = sda_oe_n_q;

  // ----------------------------------------------------------------
  // Slot storage
  // ----------------------------------------------------------------
  // Writes beyond the slot range are dropped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SLOTS; i++) begin
        slot_q[i] <= SLOT_RESET;
      end
    end else if (wr_stb && ptr_q >= REG_SLOT_FIRST && ptr_q < REG_SLOT_FIRST + 8'(SLOTS)) begin
      slot_q[SW'(ptr_q - REG_SLOT_FIRST)] <= shift_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  hsp_sstate_t    sq_q;
  logic [SW-1:0]  idx_q;
  logic           launch;

  assign launch = wr_stb & (ptr_q == REG_LAUNCH) & shift_q[LAUNCH_BIT];

  // A launch during playback is ignored; the sequence runs out first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sq_q         <= HSP_SQ_IDLE;
      idx_q        <= '0;
      wave_id_q    <= 8'h00;
      wave_start_q <= 1'b0;
      seq_busy_q   <= 1'b0;
    end else begin
      wave_start_q <= 1'b0;
      case (sq_q)
        HSP_SQ_IDLE: begin
          if (launch && slot_q[0] != WAVE_END_ID) begin
            idx_q        <= '0;
            wave_id_q    <= slot_q[0];
            wave_start_q <= 1'b1;
            seq_busy_q   <= 1'b1;
            sq_q         <= HSP_SQ_PLAY;
          end
        end
        HSP_SQ_PLAY: begin
          if (wave_done) begin
            if (idx_q == SW'(SLOTS - 1) || slot_q[idx_q + 1'b1] == WAVE_END_ID) begin
              seq_busy_q <= 1'b0;
              sq_q       <= HSP_SQ_IDLE;
            end else begin
              idx_q        <= idx_q + 1'b1;
              wave_id_q    <= slot_q[idx_q + 1'b1];
              wave_start_q <= 1'b1;
            end
          end
        end
        default: begin
          sq_q <= HSP_SQ_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== dv/haptic_sequencer_serial_port_bench.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Host controller and target joined on one bus
// ----------------------------------------------------------------
module haptic_sequencer_serial_port_bench;
  import hsp_pkg::*;
  logic       sys_clk    = 1'b0;
  logic       rst_n      = 1'b0;
  logic [3:0] reg_addr   = 4'h0;
  logic [7:0] reg_wdata  = 8'h00;
  logic       reg_wr     = 1'b0;
  logic       reg_rd     = 1'b0;
  logic       wave_done  = 1'b0;
  logic [7:0] reg_rdata_q;
  logic [7:0] wave_id_q;
  logic       wave_start_q;
  logic       seq_busy_q;
  logic [7:0] rdat;
  logic [7:0] slot_v[8];
  logic [7:0] seen[$];
  int         num_errors = 0;
  int         checked    = 0;

  hsp_if bus ();
  // Small quarter count keeps each byte near 300 cycles
  hsp_master #(.QTR_CYC(8)) u_hsp_master (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
  hsp_target u_hsp_target (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .wave_id_q(wave_id_q),
    .wave_start_q(wave_start_q), .wave_done(wave_done), .seq_busy_q(seq_busy_q));
  hsp_bus_checker u_hsp_bus_checker (.sys_clk(sys_clk), .rst_n(rst_n), .scl_m_o(bus.scl_m_o),
    .scl_m_oe_n(bus.scl_m_oe_n), .sda_m_o(bus.sda_m_o), .sda_m_oe_n(bus.sda_m_oe_n), .sda_t_o(bus.sda_t_o),
    .sda_t_oe_n(bus.sda_t_oe_n), .scl(bus.scl), .sda(bus.sda));

  always #5 sys_clk = ~sys_clk;

  // Synthesizer stand-in: each waveform ends the cycle after it starts
  always @(posedge sys_clk) begin
    wave_done <= wave_start_q;
    if (wave_start_q === 1'b1) seen.push_back(wave_id_q);
  end

  // ----------------------------------------------------------------
  // Register port and bus helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("counts: %0d checks, %0d mismatches", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Leading edge wait keeps strobes of two calls from landing in one step
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rdat = reg_rdata_q;
  endtask

  // Command then poll busy; the last status read stays in rdat
  task automatic op(logic [7:0] c);
    int n;
    n = 0;
    wr(HREG_CMD, c);
    do begin
      rd(HREG_STATUS);
      n++;
    end while (rdat[ST_BUSY] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      num_errors++;
      $display("mismatch busy expected 0 seen %b", rdat[ST_BUSY]);
      give_verdict();
    end
  endtask

  task automatic send(logic [7:0] b, logic nack);
    wr(HREG_TXDATA, b);
    op({6'h00, OP_WRITE});
    check("nack", {7'h00, nack}, {7'h00, rdat[ST_NACK]});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_slots();
    op({6'h00, OP_START});
    send(8'hB2, 1'b0);
    send(8'h03, 1'b0);
    for (int i = 0; i < 8; i++) begin
      slot_v[i] = 8'(8'h81 + 8'(i * 17));
      send(slot_v[i], 1'b0);
    end
    op({6'h00, OP_STOP});
    op({6'h00, OP_START});
    send(8'hB2, 1'b0);
    send(8'h03, 1'b0);
    op({6'h00, OP_START});
    send(8'hB3, 1'b0);
    for (int i = 0; i < 8; i++) begin
      op({5'h00, i == 7, OP_READ});
      rd(HREG_RXDATA);
      check("slot", slot_v[i], rdat);
    end
    op({6'h00, OP_STOP});
    $display("test slots done");
  endtask

  task automatic t_foreign();
    op({6'h00, OP_START});
    send(8'hB4, 1'b1);
    send(8'h03, 1'b1);
    op({6'h00, OP_STOP});
    rd(4'hF);
    check("unmapped", 8'h00, rdat);
    $display("test foreign done");
  endtask

  // Launch through a full transmit buffer; a third push must be dropped
  task automatic t_play(int n);
    int w;
    seen.delete();
    wr(HREG_TXDATA, 8'hB2);
    wr(HREG_TXDATA, 8'h02);
    wr(HREG_TXDATA, 8'h54);
    rd(HREG_STATUS);
    check("full", 8'h01, {7'h00, rdat[ST_TX_FULL]});
    op({6'h00, OP_START});
    op({6'h00, OP_WRITE});
    op({6'h00, OP_WRITE});
    send(8'h01, 1'b0);
    op({6'h00, OP_STOP});
    check("empty", 8'h01, {7'h00, rdat[ST_TX_EMPTY]});
    w = 0;
    while (seq_busy_q !== 1'b0 && w < 1000) begin
      @(posedge sys_clk);
      w++;
    end
    if (w >= 1000) begin
      num_errors++;
      $display("mismatch seq_busy expected 0 seen %b", seq_busy_q);
      give_verdict();
    end
    check("count", 8'(n), 8'(seen.size()));
    for (int i = 0; i < n && i < seen.size(); i++)
      check("wave", slot_v[i], seen[i]);
    $display("test play %0d done", n);
  endtask

  task automatic t_zero_stop();
    slot_v[3] = 8'h00;
    op({6'h00, OP_START});
    send(8'hB2, 1'b0);
    send(8'h06, 1'b0);
    send(8'h00, 1'b0);
    op({6'h00, OP_STOP});
    t_play(3);
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_slots();
    t_foreign();
    t_play(8);
    t_zero_stop();
    give_verdict();
  end
endmodule

// ==== dv/hsp_bus_checker.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Line checks on the shared two-wire bus
// ----------------------------------------------------------------
module hsp_bus_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_m_o,
  input wire logic scl_m_oe_n,
  input wire logic sda_m_o,
  input wire logic sda_m_oe_n,
  input wire logic sda_t_o,
  input wire logic sda_t_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Pads may only pull low; a high drive would fight the pull-up
  chk_pads_pull_low: assert property (!scl_m_o && !sda_m_o && !sda_t_o)
    else $error("pad value driven high");
  chk_idle_release: assert property ($rose(rst_n) |-> scl && sda)
    else $error("bus not idle after reset");
  chk_tgt_data_timing: assert property ($changed(sda_t_oe_n) |-> !scl)
    else $error("target moved data while clock high");
  chk_ack_whole_high: assert property (!sda_t_oe_n && scl |=> !sda_t_oe_n || !scl)
    else $error("target let go during clock high");
  chk_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  chk_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  chk_start_then_low: assert property ($fell(sda) && scl |-> ##[1:20] !scl)
    else $error("start not followed by clock low");
  chk_stop_holds_bus: assert property ($rose(sda) && scl |-> (scl && sda) [*8])
    else $error("bus not released after stop");
  chk_tgt_release: assert property ($fell(sda_t_oe_n) |-> ##[1:400] sda_t_oe_n)
    else $error("target kept the data line");
endmodule
